// >>> hw/icd_top.sv
/*
  Input clock divider with local phase offset and automatic phase
  adjustment on the timing reference, reached over classic Wishbone.
  Assumes mclk ticks once per half cycle of the input device clock,
  and sysref_evt is a one-cycle pulse synchronous to mclk.
*/
`timescale 1ns/10ps
`include "icd_consts.svh"
module icd_top (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sysref_evt,
  output logic div_clk_o,
  output logic clk_inv_o
);

  // Half-cycles in one half of the divided period
  function automatic logic [2:0] half_len(input logic [2:0] code);
    case (code)
      `ICD_DIV2_CODE: half_len = `ICD_HALF_DIV2;
      `ICD_DIV4_CODE: half_len = `ICD_HALF_DIV4;
      default: half_len = `ICD_HALF_DIV1;
    endcase
  endfunction

  icd_pkg::icd_cfg_type cfg_ff;
  icd_pkg::icd_cfg_type nxt_cfg;
  icd_pkg::icd_bus_type bus_ff;
  icd_pkg::icd_bus_type nxt_bus;
  logic [31:0] rdat_ff;
  logic [31:0] nxt_rdat;
  logic [3:0] capt_ff;
  logic [3:0] nxt_capt;
  logic [2:0] ph_ff;
  logic [2:0] nxt_ph;
  logic inv_ff;
  logic nxt_inv;
  logic [3:0] eff_off;
  logic [2:0] half;
  logic raw_clk;
  logic req;
  logic wr_ok;
  logic [9:0] idx;
  logic [4:0] up_ff;
  logic [4:0] nxt_up;

  assign req = wb_cyc_i && wb_stb_i;
  assign wr_ok = wb_we_i && wb_sel_i[0];
  assign idx = wb_adr_i[11:2];

  // Read mux, answer one cycle after request; write lands with ack
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_bus = icd_pkg::ICD_BUS_IDLE;
    nxt_rdat = rdat_ff;
    case (bus_ff)
      icd_pkg::ICD_BUS_IDLE: begin
        if (req) begin
          nxt_bus = icd_pkg::ICD_BUS_ACK;
          nxt_rdat = 32'h0000_0000;
          case (idx)
            `ICD_IDX_RATIO: begin
              nxt_rdat[`ICD_RATIO_MSB:0] = cfg_ff.ratio;
            end
            `ICD_IDX_PHASE: begin
              nxt_rdat[`ICD_PHASE_MSB:0] = cfg_ff.local_off;
            end
            `ICD_IDX_SYNC: begin
              nxt_rdat[`ICD_AUTO_BIT] = cfg_ff.auto_en;
              nxt_rdat[`ICD_SKEW_MSB:0] = cfg_ff.skew;
            end
            `ICD_IDX_CAPT: begin
              nxt_rdat[3:0] = capt_ff;
            end
            default: begin
              nxt_rdat = 32'h0000_0000;
            end
          endcase
        end
      end
      icd_pkg::ICD_BUS_ACK: begin
        nxt_bus = icd_pkg::ICD_BUS_IDLE;
        // Write takes effect at the edge where the master sees ack
        if (req && wr_ok) begin
          case (idx)
            `ICD_IDX_RATIO: begin
              nxt_cfg.ratio = wb_dat_i[`ICD_RATIO_MSB:0];
            end
            `ICD_IDX_PHASE: begin
              nxt_cfg.local_off = wb_dat_i[`ICD_PHASE_MSB:0];
            end
            `ICD_IDX_SYNC: begin
              nxt_cfg.auto_en = wb_dat_i[`ICD_AUTO_BIT];
              nxt_cfg.skew = wb_dat_i[`ICD_SKEW_MSB:0];
            end
            default: begin
              nxt_cfg = cfg_ff;
            end
          endcase
        end
      end
      default: begin
        nxt_bus = icd_pkg::ICD_BUS_IDLE;
      end
    endcase
  end

  // Bus and configuration registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ff <= '{ratio: `ICD_RATIO_RST, local_off: `ICD_PHASE_RST,
                  auto_en: 1'b0, skew: 4'h0};
      bus_ff <= icd_pkg::ICD_BUS_IDLE;
      rdat_ff <= 32'h0000_0000;
    end else begin
      cfg_ff <= nxt_cfg;
      bus_ff <= nxt_bus;
      rdat_ff <= nxt_rdat;
    end
  end

  assign wb_ack_o = (bus_ff == icd_pkg::ICD_BUS_ACK);
  assign wb_dat_o = rdat_ff;

  // Effective offset: captured phase added in auto mode only
  always_comb begin
    if (cfg_ff.auto_en) begin
      eff_off = 4'(capt_ff + cfg_ff.local_off);
    end else begin
      eff_off = cfg_ff.local_off;
    end
  end

  assign half = half_len(cfg_ff.ratio);
  // Undelayed divided clock: high for first half of the period
  assign raw_clk = (ph_ff < half);

  // Half-cycle phase counter, capture of phase at reference event
  always_comb begin
    if (ph_ff >= (half + half - 3'h1)) begin
      nxt_ph = 3'h0;
    end else begin
      nxt_ph = ph_ff + 3'h1;
    end
    nxt_capt = capt_ff;
    if (cfg_ff.auto_en && sysref_evt) begin
      nxt_capt = {1'b0, ph_ff};
    end
    nxt_inv = eff_off[0];
    nxt_up = (up_ff == 5'h1F) ? up_ff : up_ff + 5'h01;
  end

  // Divider state registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ph_ff <= 3'h0;
      capt_ff <= `ICD_CAPT_RST;
      inv_ff <= 1'b0;
      up_ff <= 5'h00;
    end else begin
      ph_ff <= nxt_ph;
      capt_ff <= nxt_capt;
      inv_ff <= nxt_inv;
      up_ff <= nxt_up;
    end
  end

  assign clk_inv_o = inv_ff;

  // Delay by eff_off half-cycles, up to fifteen
  icd_delay_line #(
    .DEPTH(16),
    .TAPW(4)
  ) u_delay (
    .mclk(mclk),
    .rst_b(rst_b),
    .din(raw_clk),
    .tap(eff_off),
    .dout(div_clk_o)
  );

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_ACK_REQ: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  AST_CAPTURE: assert property (
    cfg_ff.auto_en && sysref_evt |=> capt_ff == {1'b0, $past(ph_ff)})
    else $error("phase not captured at reference event");
  AST_NO_AUTO: assert property (
    !cfg_ff.auto_en |=> $stable(capt_ff))
    else $error("capture changed with auto disabled");
  AST_EFF_SUM: assert property (
    cfg_ff.auto_en |-> eff_off == 4'(capt_ff + cfg_ff.local_off))
    else $error("effective offset not capture plus local");
  AST_INVERT: assert property (
    ##1 clk_inv_o == $past(eff_off[0]))
    else $error("inversion does not follow offset lsb");
  AST_ZERO_DLY: assert property (
    eff_off == 4'h0 |=> div_clk_o == $past(raw_clk))
    else $error("code zero adds delay");
  AST_MAX_DLY: assert property (
    eff_off == 4'hF && up_ff > 5'h11 |=> div_clk_o == $past(raw_clk, 16))
    else $error("top code is not fifteen half-cycles");
  AST_DIV4: assert property (
    cfg_ff.ratio == `ICD_DIV4_CODE && ph_ff == 3'h7 |=> ph_ff == 3'h0)
    else $error("divide by four period wrong");
  AST_DIV1: assert property (
    cfg_ff.ratio == 3'h0 && ph_ff <= 3'h1 |=> ph_ff <= 3'h1)
    else $error("divide by one period wrong");

endmodule

// >>> common/icd_consts.svh
/*
  Constants of the input clock divider: register indices, field
  positions, reset values and divider codes.
  Assumes inclusion by bare name from any design file.
*/
`ifndef ICD_CONSTS_SVH
`define ICD_CONSTS_SVH

// Register indices; the byte address is four times the index
`define ICD_IDX_RATIO 10'h108
`define ICD_IDX_PHASE 10'h109
`define ICD_IDX_SYNC 10'h10A
`define ICD_IDX_CAPT 10'h129

// Field positions
`define ICD_RATIO_MSB 2
`define ICD_PHASE_MSB 3
`define ICD_AUTO_BIT 7
`define ICD_SKEW_MSB 3

// Reset values
`define ICD_RATIO_RST 3'h0
`define ICD_PHASE_RST 4'h0
`define ICD_SYNC_RST 8'h00
`define ICD_CAPT_RST 4'h0

// Divider ratio codes
`define ICD_DIV2_CODE 3'h1
`define ICD_DIV4_CODE 3'h3

// Half-cycles per half of the divided period at divide by 1, 2 and 4
`define ICD_HALF_DIV1 3'h1
`define ICD_HALF_DIV2 3'h2
`define ICD_HALF_DIV4 3'h4

`endif

// >>> common/icd_pkg.sv
/*
  Types of the input clock divider.
  Assumes icd_consts.svh for the numeric constants.
*/
package icd_pkg;

  // Software configuration carried to the divider logic
  typedef struct packed {
    logic [2:0] ratio;
    logic [3:0] local_off;
    logic auto_en;
    logic [3:0] skew;
  } icd_cfg_type;

  // Register bus answer state
  typedef enum logic [1:0] {
    ICD_BUS_IDLE = 2'b01,
    ICD_BUS_ACK = 2'b10
  } icd_bus_type;

endpackage

// >>> hw/icd_delay_line.sv
/*
  Tapped delay line in half input-clock steps with a registered tap.
  Assumes mclk ticks once per half input-clock cycle.
*/
`timescale 1ns/10ps
module icd_delay_line #(
  parameter int DEPTH = 16,
  parameter int TAPW = 4
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic din,
  input wire logic [TAPW-1:0] tap,
  output logic dout
);

  logic [DEPTH-1:0] hist_ff;
  logic [DEPTH-1:0] nxt_hist;
  logic dout_ff;
  logic nxt_dout;

  // Shift history; tap zero passes the current level
  always_comb begin
    nxt_hist = {hist_ff[DEPTH-2:0], din};
    if (tap == '0) begin
      nxt_dout = din;
    end else begin
      nxt_dout = hist_ff[tap - TAPW'(1)];
    end
  end

  // History and tap registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hist_ff <= '0;
      dout_ff <= 1'b0;
    end else begin
      hist_ff <= nxt_hist;
      dout_ff <= nxt_dout;
    end
  end

  assign dout = dout_ff;

endmodule

// >>> sim/icd_ref_src.sv
/* Reference source: one-tick event some ticks after a request.
   Assumes fire is a one-tick pulse on mclk. */
`timescale 1ns/10ps
module icd_ref_src (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic fire,
  input wire logic [3:0] dly,
  output logic sysref_evt
);
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  // Load delay on request, count down
  always_comb begin
    nxt_cnt = cnt_ff;
    if (fire) begin
      nxt_cnt = {1'b0, dly} + 5'h01;
    end else if (cnt_ff != 5'h00) begin
      nxt_cnt = cnt_ff - 5'h01;
    end
  end
  // Counter register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 5'h00;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
  assign sysref_evt = (cnt_ff == 5'h01); // One tick wide
endmodule

// >>> sim/icd_top_tb_top.sv
/* Bench: registers, ratios, offsets, auto phase.
   Assumes one mclk tick per half input cycle. */
`timescale 1ns/10ps
`include "icd_consts.svh"
module icd_top_tb_top;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic fire = 1'b0;
  logic [3:0] sel = 4'hF;
  logic [3:0] dly = 4'h0;
  logic [11:0] adr = 12'h000;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat, q;
  logic ack, sref, dclk, cinv;
  int fails = 0;
  int total_checks = 0;
  int seed = 32'h39a78e25;
  int tick = 0;
  int r0, r, p, k;
  int tbl[5] = '{0, 1, 2, 14, 15};
  // Clock and tick count
  always #5 mclk = ~mclk;
  always @(posedge mclk) tick <= tick + 1;
  icd_top u_icd_top (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sysref_evt(sref), .div_clk_o(dclk), .clk_inv_o(cinv));
  icd_ref_src u_icd_ref_src (.mclk(mclk), .rst_b(rst_b),
    .fire(fire), .dly(dly), .sysref_evt(sref));
  task automatic print_verdict();
    if (fails == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    total_checks++;
    if (got !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, e);
    end
  endtask
  task automatic lost();
    fails++;
    print_verdict();
  endtask
  // Classic single cycle; holds until ack
  task automatic wb(input logic w, input logic [9:0] i,
      input logic [7:0] d);
    int n;
    @(posedge mclk);
    cyc <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    dat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) lost();
    q = rdat;
    cyc <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] i, input logic [7:0] e);
    wb(1'b0, i, 8'h00);
    chk(q, {24'h0, e});
  endtask
  // Tick of next rising edge of the divided clock
  task automatic rise(output int t);
    logic pv;
    int n;
    for (n = 0; n < 40; n++) begin
      pv = dclk;
      @(posedge mclk);
      if (pv === 1'b0 && dclk === 1'b1) break;
    end
    if (n == 40) lost();
    t = tick;
  endtask
  task automatic shift(input int e);
    repeat (24) @(posedge mclk);
    rise(r);
    chk((r - r0) % 8, e % 8);
  endtask
  task automatic pulse();
    @(posedge mclk);
    fire <= 1'b1;
    dly <= 4'($random(seed));
    @(posedge mclk);
    fire <= 1'b0;
    repeat (24) @(posedge mclk);
  endtask
  function automatic int per(input int c);
    return (c == 1) ? 4 : (c == 3) ? 8 : 2;
  endfunction
  // Main sequence
  initial begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    rd(`ICD_IDX_RATIO, 8'h00);
    rd(`ICD_IDX_CAPT, 8'h00);
    wb(1'b1, `ICD_IDX_PHASE, 8'hFF);
    rd(`ICD_IDX_PHASE, 8'h0F);
    wb(1'b1, `ICD_IDX_CAPT, 8'hFF);
    rd(`ICD_IDX_CAPT, 8'h00);
    rd(10'h000, 8'h00);
    sel <= 4'h0;
    wb(1'b1, `ICD_IDX_PHASE, 8'h03);
    sel <= 4'hF;
    rd(`ICD_IDX_PHASE, 8'h0F);
    wb(1'b1, `ICD_IDX_PHASE, 8'h00);
    // Ratio codes 0 to 3, code 2 undefined
    for (k = 0; k < 4; k++) begin
      wb(1'b1, `ICD_IDX_RATIO, 8'(k));
      repeat (24) @(posedge mclk);
      rise(r0);
      rise(r);
      chk(r - r0, per(k));
    end
    // Offsets at divide by four: corners, then random
    r0 = r;
    for (int i = 0; i < 9; i++) begin
      k = (i < 5) ? tbl[i] : ($random(seed) & 15);
      wb(1'b1, `ICD_IDX_PHASE, 8'(k));
      shift(k);
      chk(cinv, k & 1);
    end
    // Reference with auto off
    pulse();
    rd(`ICD_IDX_CAPT, 8'h00);
    shift(k);
    // Auto on: capture, combined offset
    wb(1'b1, `ICD_IDX_SYNC, 8'hF0 | 8'(k));
    rd(`ICD_IDX_SYNC, 8'h80 | 8'(k));
    pulse();
    wb(1'b0, `ICD_IDX_CAPT, 8'h00);
    p = q;
    chk(q & 32'hFFFFFFF8, 32'h0);
    shift(p + k);
    chk(cinv, (p + k) & 1);
    // Auto off again: capture kept
    wb(1'b1, `ICD_IDX_SYNC, 8'h00);
    pulse();
    rd(`ICD_IDX_CAPT, 8'(p));
    shift(k);
    print_verdict();
  end
endmodule
